// ==== core/dda_display_top.sv ====
// distortion display output: selector, decoder, bias lamps and parity check
// Functional notes
// - each bit passes average or peak, phase-chosen
// - selected value alternates and feeds the decoder
// - decoder turns four bits into sixteen lines
// - average and peak leds alternate at 50 kHz
// - line polarity: mark positive bias, space end
// - window high second half bias, first end
// - strobe on every line transition
// - bias: early rising transition lights marking lamp
// - bias: late transition lights spacing lamp
// - end mode uses mark-to-space transitions
// - per-character parity, strap picks odd or even
// - clear input resets parity at start bit
// - bit-centre pulse every bit, transition or not
// - parity toggles on each space bit centre
// - even strap flags even count, odd flags odd
// - parity result waits for end-of-data strobe
// - parity error drives output low
// - error stays until button pressed then released
// - average latch loads once per measurement period
`default_nettype none
`include "dda_cfg.svh"
module dda_display_top
(
  // clock and reset
  input  wire  logic               clk_sys_in,
  input  wire  logic               rst_in,
  // measurement values, same clock
  input  wire  dda_pkg::dda_nib_t  avg_count_bits_in,
  input  wire  logic               avg_load_in,
  input  wire  dda_pkg::dda_nib_t  peak_bits_in,
  // line level pin and timing, same clock except the pin
  input  wire  logic               line_mark_pin_in,
  input  wire  logic               bit_timing_in,
  input  wire  logic               char_clear_in,
  input  wire  logic               end_of_data_half_in,
  // straps and operator pushbutton, pins
  input  wire  logic               bias_mode_pin_in,
  input  wire  logic               parity_odd_pin_in,
  input  wire  logic               reset_button_pin_in,
  // display
  output logic                     display_phase_select_out,
  output var   dda_pkg::dda_nib_t  muxed_value_bits_out,
  output var   dda_pkg::dda_led_t  led_out,
  // indicators
  output var   dda_pkg::dda_lamps_t lamps_out,
  output logic                     transition_strobe_out,
  output logic                     parity_error_n_out
);
  import dda_pkg::*;

  // synchroniser stages for all pin inputs
  logic [`DDA_SYNC_W-1:0] pin_meta_reg;   // first stage, read only by second
  logic [`DDA_SYNC_W-1:0] pin_sync_reg;   // second stage, safe to use
  logic                   line_prev_reg;  // synced line one cycle back
  logic                   tb_prev_reg;    // bit timing one cycle back
  logic [`DDA_PRIME_W-1:0] prime_reg;     // edge detector live once filled
  // display phase divider
  logic [`DDA_PHASE_CNT_W-1:0] phase_cnt_reg;  // cycles into half period
  logic [`DDA_PHASE_CNT_W-1:0] phase_cnt_next; // counter next value
  logic                        phase_reg;      // high shows peak
  logic                        phase_wrap;     // half period over
  // display path
  dda_nib_t   avg_reg;     // average latch
  dda_nib_t   muxed_next;  // selector output
  dda_nib_t   muxed_reg;   // registered selector output
  dda_led_t   led_next;    // decoder output
  dda_led_t   led_reg;     // registered led lines
  dda_pair_t  pair_w;      // values offered to the selector
  // bias indicator
  dda_lamps_t lamps_reg;             // held lamp choice
  logic       line_sync;             // synced line, high is mark
  logic       bias_mode;             // high in bias, low in end mode
  logic       polarity_adjusted_line;// positive for the measured level
  logic       polarity_prev;         // same, one cycle back
  logic       transition_strobe;     // any line change
  logic       half_bit_window;       // early-transition window
  logic       qualify;               // controlling transition seen
  // parity checker
  logic       space_level;           // high during a space
  logic       bit_timing_pulse;      // centre of every bit
  logic       parity_reg;            // high after odd space count
  logic       parity_odd_strap;      // high flags odd counts
  logic       parity_bad;            // count disagrees with strap
  logic       err_reg;               // latched parity error
  logic       err_next;              // latched error next value
  dda_btn_t   btn_reg;               // pushbutton state
  dda_btn_t   btn_next;              // pushbutton next state
  logic       btn_release;           // press finished this cycle
  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_meta_reg <= `DDA_SYNC_RST;
      pin_sync_reg <= `DDA_SYNC_RST;
    end
    else
    begin
      pin_meta_reg <= {reset_button_pin_in, parity_odd_pin_in,
                       bias_mode_pin_in, line_mark_pin_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // names of the synced levels
  assign line_sync        = pin_sync_reg[`DDA_SYNC_LINE];
  assign bias_mode        = pin_sync_reg[`DDA_SYNC_BIAS];
  assign parity_odd_strap = pin_sync_reg[`DDA_SYNC_ODD];

  // previous samples for edge detection; priming hides the reset edge of a mark-idle line
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      line_prev_reg <= `DDA_BIT_RST;
      tb_prev_reg   <= `DDA_BIT_RST;
      prime_reg     <= `DDA_PRIME_RST;
    end
    else
    begin
      line_prev_reg <= line_sync;
      tb_prev_reg   <= bit_timing_in;
      prime_reg     <= {`DDA_BIT_SET, prime_reg[`DDA_PRIME_W-1:1]};
    end
  end

  // free-running divider, one toggle per half period
  assign phase_wrap     = (phase_cnt_reg ==
                           `DDA_PHASE_CNT_W'(`DDA_PHASE_HALF_CYC - 1));
  assign phase_cnt_next = phase_wrap ? `DDA_PHASE_CNT_RST
                                     : phase_cnt_reg + `DDA_PHASE_CNT_W'(1);

  // phase toggles every half period, giving 50 kHz
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_cnt_reg <= `DDA_PHASE_CNT_RST;
      phase_reg     <= `DDA_BIT_RST;
    end
    else
    begin
      phase_cnt_reg <= phase_cnt_next;
      if (phase_wrap)
      begin
        phase_reg <= ~phase_reg;
      end
    end
  end

  // average latch, loaded only on the period-end strobe
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      avg_reg <= `DDA_NIB_RST;
    end
    else if (avg_load_in)
    begin
      avg_reg <= avg_count_bits_in;
    end
  end

  // peak value arrives already latched upstream
  assign pair_w = '{avg: avg_reg, peak: peak_bits_in};

  // selector between the two values
  dda_mux u_mux
  (
    .pair_in   (pair_w),
    .phase_in  (phase_reg),
    .muxed_out (muxed_next)
  );

  // decoder fed from the registered selector output
  dda_decode u_decode
  (
    .code_in   (muxed_reg),
    .lines_out (led_next)
  );

  // display registers; leds lag the code by one cycle, invisible at 50 kHz
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      muxed_reg <= `DDA_NIB_RST;
      led_reg   <= `DDA_LED_RST;
    end
    else
    begin
      muxed_reg <= muxed_next;
      led_reg   <= led_next;
    end
  end

  // mode picks which line level counts as positive
  assign polarity_adjusted_line = bias_mode ? line_sync : ~line_sync;
  assign polarity_prev          = bias_mode ? line_prev_reg : ~line_prev_reg;
  // any synced line change is a transition; edges in the first three cycles are lost
  assign transition_strobe      = (line_sync ^ line_prev_reg) & prime_reg[`DDA_LIVE];
  // bit timing is high in the first half of each bit
  assign half_bit_window        = bias_mode ? ~bit_timing_in : bit_timing_in;
  // rising adjusted line: space-to-mark in bias, mark-to-space in end
  assign qualify = transition_strobe & polarity_adjusted_line & ~polarity_prev;

  // lamp choice, held between controlling transitions
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lamps_reg <= '{mark: `DDA_BIT_RST, space: `DDA_BIT_RST};
    end
    else if (qualify)
    begin
      // early transition marks, late transition spaces
      lamps_reg <= '{mark: half_bit_window, space: ~half_bit_window};
    end
    // otherwise hold, so the lamp survives non-qualifying edges
  end

  // space is the low line level; parity counts space bit periods
  assign space_level      = ~line_sync;
  // falling bit timing marks the centre of every bit
  assign bit_timing_pulse = tb_prev_reg & ~bit_timing_in;

  // space-bit counter, one flop toggling per space bit
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      parity_reg <= `DDA_BIT_RST;
    end
    else if (char_clear_in)
    begin
      parity_reg <= `DDA_BIT_RST;
    end
    else if (bit_timing_pulse && space_level)
    begin
      parity_reg <= ~parity_reg;
    end
  end

  // strap decides which count is wrong, for any code length
  assign parity_bad = parity_odd_strap ? parity_reg : ~parity_reg;

  // pushbutton: a release only counts after a press was seen
  assign btn_release = (btn_reg == DDA_BTN_HELD) & ~pin_sync_reg[`DDA_SYNC_BTN];
  always_comb
  begin
    btn_next = btn_reg;
    unique case (btn_reg)
      DDA_BTN_IDLE:
        if (pin_sync_reg[`DDA_SYNC_BTN])
        begin
          btn_next = DDA_BTN_HELD;
        end
      DDA_BTN_HELD:
        if (!pin_sync_reg[`DDA_SYNC_BTN])
        begin
          btn_next = DDA_BTN_IDLE;
        end
    endcase
  end

  // result only taken at end of data; a fresh error beats the release
  assign err_next = (end_of_data_half_in && parity_bad) ? `DDA_BIT_SET
                  : (btn_release ? `DDA_BIT_RST : err_reg);

  // error latch and button state
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      err_reg <= `DDA_BIT_RST;
      btn_reg <= DDA_BTN_IDLE;
    end
    else
    begin
      err_reg <= err_next;
      btn_reg <= btn_next;
    end
  end

  // outputs
  assign display_phase_select_out = phase_reg;
  assign muxed_value_bits_out     = muxed_reg;
  assign led_out                  = led_reg;
  assign lamps_out                = lamps_reg;
  assign transition_strobe_out    = transition_strobe;
  assign parity_error_n_out       = ~err_reg;

  // checks on the design's own behaviour
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_qual_early;
    qualify && half_bit_window;
  endsequence
  sequence s_qual_late;
    qualify && !half_bit_window;
  endsequence

  a_mux_select: assert property (1 |=> muxed_reg ==
                                 ($past(phase_reg) ? $past(peak_bits_in) : $past(avg_reg)))
    else $error("selector passed the wrong value");
  a_phase_rate: assert property (phase_wrap |=>
                                 $changed(phase_reg) ##1 $stable(phase_reg))
    else $error("display phase did not toggle at half period");
  a_phase_hold: assert property (!phase_wrap |=> $stable(phase_reg))
    else $error("display phase toggled early");
  a_decode_onehot: assert property (1 |=>
                                    led_reg == (`DDA_LED_ONE << $past(muxed_reg)))
    else $error("decoder line does not match code");
  a_avg_load: assert property (avg_load_in |=> avg_reg == $past(avg_count_bits_in))
    else $error("average latch not loaded");
  a_avg_keep: assert property (!avg_load_in |=> $stable(avg_reg))
    else $error("average latch changed without load");
  a_mark_lamp: assert property (s_qual_early |=> lamps_reg.mark && !lamps_reg.space)
    else $error("early transition did not light marking lamp");
  a_space_lamp: assert property (s_qual_late |=> lamps_reg.space && !lamps_reg.mark)
    else $error("late transition did not light spacing lamp");
  a_lamp_hold: assert property (!qualify |=> $stable(lamps_reg))
    else $error("lamp changed without a controlling transition");
  a_parity_tog: assert property (bit_timing_pulse && space_level && !char_clear_in
                                 |=> parity_reg != $past(parity_reg))
    else $error("parity did not toggle on space bit");
  a_parity_clr: assert property (char_clear_in |=> !parity_reg)
    else $error("parity not cleared");
  a_err_wait: assert property (!end_of_data_half_in |=> !$rose(err_reg))
    else $error("parity error raised before end of data");
  a_err_clear: assert property (btn_release && !end_of_data_half_in
                                |=> parity_error_n_out)
    else $error("error lamp not cleared on release");
endmodule // dda_display_top
`default_nettype wire

// ==== core/dda_cfg.svh ====
// named constants for the distortion display output block
`ifndef DDA_CFG_SVH
`define DDA_CFG_SVH

// system clock rate in hertz (5 ns period)
`define DDA_CLK_HZ         200000000
// display phase rate in hertz
`define DDA_PHASE_HZ       50000
// cycles per half period of the display phase, 2000 at 200 MHz
`define DDA_PHASE_HALF_CYC (`DDA_CLK_HZ / (2 * `DDA_PHASE_HZ))
// width of the phase divider counter
`define DDA_PHASE_CNT_W    11
// reset value of the phase divider counter
`define DDA_PHASE_CNT_RST  11'h000

// reset values of nibble, led bank and single bits
`define DDA_NIB_RST        4'h0
`define DDA_LED_RST        16'h0000
`define DDA_LED_ONE        16'h0001
`define DDA_BIT_RST        1'b0
`define DDA_BIT_SET        1'b1

// bit positions inside the synchroniser vector
`define DDA_SYNC_W         4
`define DDA_SYNC_RST       4'h0
`define DDA_SYNC_LINE      0
`define DDA_SYNC_BIAS      1
`define DDA_SYNC_ODD       2
`define DDA_SYNC_BTN       3

// edge detector priming: a shift of ones, live once its low bit is set
`define DDA_PRIME_W        3
`define DDA_PRIME_RST      3'h0
`define DDA_LIVE           0

`endif

// ==== core/dda_pkg.sv ====
// types shared by the distortion display output block
`default_nettype none
package dda_pkg;
  // one four-bit distortion value
  typedef logic [3:0]  dda_nib_t;
  // one-of-sixteen led bank
  typedef logic [15:0] dda_led_t;
  // marking and spacing indicator pair
  typedef struct packed {
    logic mark;   // marking bias lamp
    logic space;  // spacing bias lamp
  } dda_lamps_t;
  // pair of values time-shared onto the display
  typedef struct packed {
    dda_nib_t avg;   // average distortion
    dda_nib_t peak;  // peak distortion
  } dda_pair_t;
  // operator reset pushbutton tracking
  typedef enum logic [0:0] {
    DDA_BTN_IDLE = 1'b0,
    DDA_BTN_HELD = 1'b1
  } dda_btn_t;
endpackage : dda_pkg
`default_nettype wire

// ==== core/dda_mux.sv ====
// average/peak time-share selector
`default_nettype none
module dda_mux
(
  // values to share
  input  wire dda_pkg::dda_pair_t pair_in,
  // display phase, high selects peak
  input  wire logic               phase_in,
  // selected value
  output var  dda_pkg::dda_nib_t  muxed_out
);
  import dda_pkg::*;

  // exactly one source passes per bit, never a blend
  assign muxed_out = phase_in ? pair_in.peak : pair_in.avg;
endmodule // dda_mux
`default_nettype wire

// ==== core/dda_decode.sv ====
// four-to-sixteen display decoder
`default_nettype none
`include "dda_cfg.svh"
module dda_decode
(
  // binary code from the selector
  input  wire dda_pkg::dda_nib_t code_in,
  // one line per display led
  output var  dda_pkg::dda_led_t lines_out
);
  import dda_pkg::*;

  // one-hot of a code, line index equals the code value
  function automatic dda_led_t dda_onehot(input dda_nib_t code);
    dda_onehot = `DDA_LED_ONE << code;
  endfunction

  // all sixteen codes are legal, so no line is left undriven
  assign lines_out = dda_onehot(code_in);
endmodule // dda_decode
`default_nettype wire

// ==== test/dda_led_panel.sv ====
// led bar panel model: records what each display phase lit
`default_nettype none
module dda_led_panel
(
  // clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  // driven by the block
  input  wire logic               phase_in,
  input  wire dda_pkg::dda_led_t  led_in,
  // what the operator saw
  output var  dda_pkg::dda_led_t  avg_seen_out,
  output var  dda_pkg::dda_led_t  peak_seen_out,
  output var  logic [15:0]        half_len_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import dda_pkg::*;
  logic [1:0]  ph_dly_reg; // phase delayed to line up with the led bank
  logic [15:0] cnt_reg;    // cycles since the last phase change
  // the led bank trails the phase by two cycles, so the delayed phase picks the slot
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ph_dly_reg    <= 2'h0;
      cnt_reg       <= 16'h0000;
      half_len_out  <= 16'h0000;
      avg_seen_out  <= 16'h0000;
      peak_seen_out <= 16'h0000;
    end
    else
    begin
      ph_dly_reg <= {ph_dly_reg[0], phase_in};
      // each half lights one value; both appear steady to the eye
      if (ph_dly_reg[1])
        peak_seen_out <= led_in;
      else
        avg_seen_out <= led_in;
      // length of one phase half, the blink rate
      if (phase_in != ph_dly_reg[0])
      begin
        half_len_out <= cnt_reg;
        cnt_reg      <= 16'h0001;
      end
      else
        cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule // dda_led_panel
`default_nettype wire

// ==== test/dda_display_top_tb.sv ====
// self-checking bench for the distortion display output block
`default_nettype none
`include "dda_cfg.svh"
module dda_display_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dda_pkg::*;
  logic        clk_sys_in, rst_in;    // clock and reset
  dda_nib_t    avg_bits, peak_bits;   // measurement values
  logic        avg_load, line_pin;    // latch load and line level
  logic        bt, clr, eod;          // bit timing, clear, end of data
  logic        bias_pin, odd_pin, btn; // straps and pushbutton
  logic        phase, strobe, err_n;  // block flags
  dda_nib_t    muxed;                 // shared value
  dda_led_t    led, avg_seen, peak_seen; // led bank and panel view
  dda_lamps_t  lamps;                 // bias lamps
  logic [15:0] half_len;              // measured phase half
  int          n_errors, compares, n_strobe;

  dda_display_top dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .avg_count_bits_in(avg_bits), .avg_load_in(avg_load), .peak_bits_in(peak_bits),
    .line_mark_pin_in(line_pin), .bit_timing_in(bt), .char_clear_in(clr),
    .end_of_data_half_in(eod), .bias_mode_pin_in(bias_pin), .parity_odd_pin_in(odd_pin),
    .reset_button_pin_in(btn), .display_phase_select_out(phase),
    .muxed_value_bits_out(muxed), .led_out(led), .lamps_out(lamps),
    .transition_strobe_out(strobe), .parity_error_n_out(err_n));

  dda_led_panel panel_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .phase_in(phase),
    .led_in(led), .avg_seen_out(avg_seen), .peak_seen_out(peak_seen),
    .half_len_out(half_len));

  // 200 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // count strobe pulses, one sample per cycle
  always @(posedge clk_sys_in)
    if (strobe === 1'b1)
      n_strobe++;

  // step to the next falling edge, where inputs change
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // compare a multi-bit result
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // compare a single flag
  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // print counts and verdict, then stop
  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one line change; pin sync plus lamp update fit well inside six cycles
  task automatic line_step(input logic lvl, input logic bt_v, input logic [1:0] exp);
    int s0;
    s0 = n_strobe;
    bt = bt_v;
    line_pin = lvl;
    cyc(6);
    chk_val(16'(n_strobe - s0), 16'h0001, "strobe count");
    chk_val({14'h0000, lamps}, {14'h0000, exp}, "bias lamps");
  endtask

  // one data bit; the timing level falls mid-bit after the pin has synced
  task automatic send_bit(input logic lvl);
    line_pin = lvl;
    bt = 1'b1;
    cyc(4);
    bt = 1'b0;
    cyc(4);
  endtask

  // one character, then the lamp and its pushbutton clearing
  task automatic run_char(input logic odd_v, input int nsp, input int nmk, input logic exp_n);
    odd_pin = odd_v;
    send_bit(1'b0); // stray space bit that the clear has to wipe
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    for (int i = 0; i < nsp; i++)
      send_bit(1'b0);
    for (int i = 0; i < nmk; i++)
      send_bit(1'b1);
    chk_bit(err_n, 1'b1, "lamp before end of data");
    eod = 1'b1;
    cyc(1);
    eod = 1'b0;
    cyc(2);
    chk_bit(err_n, exp_n, "parity lamp");
    cyc(20);
    btn = 1'b1;
    cyc(4);
    chk_bit(err_n, exp_n, "lamp held while pressed");
    btn = 1'b0;
    cyc(5);
    chk_bit(err_n, 1'b1, "lamp cleared on release");
  endtask

  // watchdog, far beyond the few thousand cycles the tests need
  initial
  begin
    #(`DDA_PHASE_HALF_CYC * 5 * 10);
    n_errors++;
    $display("mismatch %0t watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial
  begin
    rst_in = 1'b1;
    avg_bits = 4'h0;
    peak_bits = 4'h9;
    {avg_load, line_pin, bt, clr, eod, odd_pin, btn} = 7'h00;
    bias_pin = 1'b1;
    n_errors = 0;
    compares = 0;
    n_strobe = 0;
    cyc(5);
    chk_val({phase, lamps, strobe, err_n, muxed, 7'h00}, 16'h0800, "reset state");
    chk_val(led, 16'h0000, "reset leds");
    cyc(1);
    rst_in = 1'b0;
    // every code through the average latch and the decoder, one load every four cycles
    for (int v = 0; v < 16; v++)
    begin
      avg_bits = 4'(v);
      avg_load = 1'b1;
      cyc(1);
      avg_load = 1'b0;
      cyc(3);
      chk_val({12'h000, muxed}, 16'(v), "average selected");
      chk_val(led, 16'h0001 << v, "one-of-sixteen");
    end
    // peak half of the display phase
    for (int i = 0; i < 2100 && phase !== 1'b1; i++)
      cyc(1);
    cyc(3);
    chk_val({12'h000, muxed}, 16'h0009, "peak selected");
    chk_val(led, 16'h0200, "peak led");
    cyc(2010);
    chk_bit(phase, 1'b0, "phase back to average");
    chk_val(half_len, 16'(`DDA_PHASE_HALF_CYC), "phase half length");
    chk_val(avg_seen, 16'h8000, "panel average");
    chk_val(peak_seen, 16'h0200, "panel peak");
    // bias mode, mark positive; window is the late half of the bit
    line_step(1'b1, 1'b0, 2'b10);
    line_step(1'b0, 1'b0, 2'b10);
    line_step(1'b1, 1'b1, 2'b01);
    // end mode, space positive; window is the early half
    bias_pin = 1'b0;
    cyc(4);
    line_step(1'b0, 1'b1, 2'b10);
    line_step(1'b1, 1'b0, 2'b10);
    line_step(1'b0, 1'b0, 2'b01);
    // both straps, 7 and 8 bit characters, runs of space bits
    run_char(1'b0, 0, 7, 1'b0);
    run_char(1'b0, 3, 4, 1'b1);
    run_char(1'b0, 2, 6, 1'b0);
    run_char(1'b1, 3, 5, 1'b0);
    run_char(1'b1, 4, 3, 1'b1);
    // second reset with the line idling at mark: no false edge may follow it
    rst_in = 1'b1;
    cyc(2);
    n_strobe = 0;
    rst_in = 1'b0;
    cyc(6);
    chk_val(16'(n_strobe), 16'h0000, "strobe after reset");
    chk_val({14'h0000, lamps}, 16'h0000, "lamps after reset");
    end_sim();
  end
endmodule // dda_display_top_tb
`default_nettype wire
